// ### hbd_pkg.sv
// Constants shared by the half-bridge diagnosis status word design
package hbd_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_BRIDGES = 6;
	localparam int WORD_BITS = 16;
	localparam int CNT_W = 5;
	localparam int SYNC_W = 16;

	// ----------------------------------------------------------------
	// Status word field positions
	// ----------------------------------------------------------------
	localparam int BIT_OC = 15;
	localparam int BIT_PSF = 14;
	localparam int BIT_OL = 13;
	localparam int BIT_ACT_LO = 7;
	localparam int BIT_SIDE_LO = 1;
	localparam int BIT_TW = 0;

	// ----------------------------------------------------------------
	// Control word field positions
	// ----------------------------------------------------------------
	localparam int CTL_CLR = 15;
	localparam int CTL_SEL = 14;
	localparam int CTL_OLEN = 13;
	localparam int CTL_ACT_LO = 7;
	localparam int CTL_SIDE_LO = 1;

	// ----------------------------------------------------------------
	// Synchroniser bit positions
	// ----------------------------------------------------------------
	localparam int SY_CSN = 0;
	localparam int SY_OC_LO = 1;
	localparam int SY_OL_LO = 7;
	localparam int SY_PSF = 13;
	localparam int SY_TW = 14;
	localparam int SY_TSD = 15;

	// ----------------------------------------------------------------
	// Counts, masks and reset values
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] FRAME_LEN = 5'h10;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
	localparam logic [WORD_BITS-1:0] FIRST_MASK = 16'h4001;
	localparam logic [WORD_BITS-1:0] STATUS_RST = 16'h0000;
	localparam logic [SYNC_W-1:0] SYNC_RST = 16'h0001;
	localparam logic [NUM_BRIDGES-1:0] BRIDGE_RST = 6'h00;
	localparam logic OLEN_RST = 1'b0;
	localparam logic FIRST_RST = 1'b1;
	localparam logic CSN_IDLE = 1'b1;
endpackage

// ### hbd_spi_link.sv
// Serial shift logic on the link clock for the diagnosis word
`timescale 1ns/10ps
module hbd_spi_link (
	// Link pins
	input wire logic link_sclk,
	input wire logic spi_csn_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	// System side
	input wire logic [hbd_pkg::WORD_BITS-1:0] tx_word,
	output logic [hbd_pkg::WORD_BITS-1:0] rx_word,
	output logic [hbd_pkg::CNT_W-1:0] rx_count
);
	logic fresh_r;
	logic sdo_nxt;
	logic [hbd_pkg::WORD_BITS-1:0] tx_r;
	logic [hbd_pkg::WORD_BITS-1:0] tx_nxt;
	logic [hbd_pkg::WORD_BITS-1:0] rx_nxt;
	logic [hbd_pkg::CNT_W-1:0] cnt_nxt;

	// ----------------------------------------------------------------
	// Shift path
	// ----------------------------------------------------------------
	// First edge of a frame loads the frozen status word
	always_comb begin
		rx_nxt = {rx_word[hbd_pkg::WORD_BITS-2:0], spi_sdi};
		if (fresh_r) begin
			cnt_nxt = hbd_pkg::CNT_ONE;
			tx_nxt = {tx_word[hbd_pkg::WORD_BITS-2:0], 1'b0};
			sdo_nxt = tx_word[hbd_pkg::WORD_BITS-1];
		end else begin
			if (rx_count == hbd_pkg::CNT_MAX) begin
				cnt_nxt = hbd_pkg::CNT_MAX;
			end else begin
				cnt_nxt = rx_count + hbd_pkg::CNT_ONE;
			end
			tx_nxt = {tx_r[hbd_pkg::WORD_BITS-2:0], 1'b0};
			sdo_nxt = tx_r[hbd_pkg::WORD_BITS-1];
		end
	end

	// Link clock stops between frames, so chip select itself rearms
	always_ff @(posedge link_sclk or posedge spi_csn_n) begin
		if (spi_csn_n) begin
			fresh_r <= 1'b1;
			spi_sdo <= 1'b0;
		end else begin
			fresh_r <= 1'b0;
			spi_sdo <= sdo_nxt;
		end
	end

	// Data path only; the count and word hold after the frame ends
	always_ff @(posedge link_sclk) begin
		rx_word <= rx_nxt;
		rx_count <= cnt_nxt;
		tx_r <= tx_nxt;
	end
endmodule

// ### hbd_diag_word.sv
// Diagnosis status word, fault latches and half-bridge shutdown
`timescale 1ns/10ps
module hbd_diag_word (
	// System clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Serial link
	input wire logic link_sclk,
	input wire logic spi_csn_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	// Fault sensing, asynchronous
	input wire logic [hbd_pkg::NUM_BRIDGES-1:0] overcurrent_det,
	input wire logic [hbd_pkg::NUM_BRIDGES-1:0] openload_det,
	input wire logic supply_fault,
	input wire logic temp_warn,
	input wire logic temp_shutdown,
	// Bridge drivers
	output logic [hbd_pkg::NUM_BRIDGES-1:0] high_side_switch,
	output logic [hbd_pkg::NUM_BRIDGES-1:0] low_side_switch
);
	localparam int NB = hbd_pkg::NUM_BRIDGES;
	localparam int WB = hbd_pkg::WORD_BITS;

	logic [hbd_pkg::SYNC_W-1:0] sync1_r;
	logic [hbd_pkg::SYNC_W-1:0] sync2_r;
	logic [hbd_pkg::SYNC_W-1:0] sync_nxt;
	logic csn_d_r;
	logic csn_s;
	logic [NB-1:0] oc_s;
	logic [NB-1:0] ol_s;
	logic psf_s;
	logic tw_s;
	logic tsd_s;
	logic global_off;

	logic [WB-1:0] rx_word;
	logic [hbd_pkg::CNT_W-1:0] rx_count;
	logic frame_end;
	logic frame_ok;
	logic clr_evt;

	logic [NB-1:0] cmd_act_r;
	logic [NB-1:0] cmd_act_nxt;
	logic [NB-1:0] cmd_side_r;
	logic [NB-1:0] cmd_side_nxt;
	logic ol_en_r;
	logic ol_en_nxt;
	logic first_r;
	logic first_nxt;
	logic [WB-1:0] snap_r;
	logic [WB-1:0] snap_nxt;
	logic oe_nxt;
	logic [WB-1:0] stat_word;

	logic [NB-1:0] oc_ch_r;
	logic [NB-1:0] ol_ch_r;
	wire [NB-1:0] oc_ch_nxt;
	wire [NB-1:0] ol_ch_nxt;
	wire [NB-1:0] hs_nxt;
	wire [NB-1:0] ls_nxt;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	always_comb begin
		sync_nxt = {temp_shutdown, temp_warn, supply_fault, openload_det,
			overcurrent_det, spi_csn_n};
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sync1_r <= hbd_pkg::SYNC_RST;
			sync2_r <= hbd_pkg::SYNC_RST;
			csn_d_r <= hbd_pkg::CSN_IDLE;
		end else begin
			sync1_r <= sync_nxt;
			sync2_r <= sync1_r;
			csn_d_r <= sync2_r[hbd_pkg::SY_CSN];
		end
	end

	assign csn_s = sync2_r[hbd_pkg::SY_CSN];
	assign oc_s = sync2_r[hbd_pkg::SY_OC_LO +: NB];
	assign ol_s = sync2_r[hbd_pkg::SY_OL_LO +: NB];
	assign psf_s = sync2_r[hbd_pkg::SY_PSF];
	assign tw_s = sync2_r[hbd_pkg::SY_TW];
	assign tsd_s = sync2_r[hbd_pkg::SY_TSD];
	assign global_off = psf_s | tsd_s;

	// ----------------------------------------------------------------
	// Link side
	// ----------------------------------------------------------------
	hbd_spi_link u_link (
		.link_sclk(link_sclk),
		.spi_csn_n(spi_csn_n),
		.spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo),
		.tx_word(snap_r),
		.rx_word(rx_word),
		.rx_count(rx_count)
	);

	// Link word and count are still once chip select has risen
	assign frame_end = csn_s & ~csn_d_r;
	assign frame_ok = frame_end && rx_count == hbd_pkg::FRAME_LEN &&
		!rx_word[hbd_pkg::CTL_SEL];
	assign clr_evt = frame_ok & rx_word[hbd_pkg::CTL_CLR];

	// ----------------------------------------------------------------
	// Status word
	// ----------------------------------------------------------------
	always_comb begin
		stat_word = hbd_pkg::STATUS_RST;
		stat_word[hbd_pkg::BIT_OC] = |oc_ch_r;
		stat_word[hbd_pkg::BIT_PSF] = psf_s;
		stat_word[hbd_pkg::BIT_OL] = |ol_ch_r;
		// Read back from the drivers, so faults show here
		stat_word[hbd_pkg::BIT_ACT_LO +: NB] =
			high_side_switch | low_side_switch;
		stat_word[hbd_pkg::BIT_SIDE_LO +: NB] = high_side_switch;
		stat_word[hbd_pkg::BIT_TW] = tw_s;
	end

	// ----------------------------------------------------------------
	// Control and frame state
	// ----------------------------------------------------------------
	always_comb begin
		cmd_act_nxt = cmd_act_r;
		cmd_side_nxt = cmd_side_r;
		ol_en_nxt = ol_en_r;
		first_nxt = first_r & ~frame_end;
		if (frame_ok) begin
			cmd_act_nxt = rx_word[hbd_pkg::CTL_ACT_LO +: NB];
			cmd_side_nxt = rx_word[hbd_pkg::CTL_SIDE_LO +: NB];
			ol_en_nxt = rx_word[hbd_pkg::CTL_OLEN];
		end
		// Frozen while selected so the link sees a steady word
		snap_nxt = snap_r;
		if (csn_s) begin
			if (first_r) begin
				snap_nxt = stat_word & hbd_pkg::FIRST_MASK;
			end else begin
				snap_nxt = stat_word;
			end
		end
		oe_nxt = ~csn_s;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cmd_act_r <= hbd_pkg::BRIDGE_RST;
			cmd_side_r <= hbd_pkg::BRIDGE_RST;
			ol_en_r <= hbd_pkg::OLEN_RST;
			first_r <= hbd_pkg::FIRST_RST;
			snap_r <= hbd_pkg::STATUS_RST;
			spi_sdo_oe <= 1'b0;
		end else begin
			cmd_act_r <= cmd_act_nxt;
			cmd_side_r <= cmd_side_nxt;
			ol_en_r <= ol_en_nxt;
			first_r <= first_nxt;
			snap_r <= snap_nxt;
			spi_sdo_oe <= oe_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Per-bridge fault latches and drivers
	// ----------------------------------------------------------------
	// A fault in the clearing cycle survives: set beats clear
	for (genvar i = 0; i < NB; i++) begin : g_bridge
		wire off;
		assign oc_ch_nxt[i] = oc_s[i] | (oc_ch_r[i] & ~clr_evt);
		assign ol_ch_nxt[i] = ol_s[i] | (ol_ch_r[i] & ~clr_evt);
		assign off = global_off | oc_ch_nxt[i] |
			(ol_ch_nxt[i] & ol_en_r);
		// Thermal warning alone never gates a bridge
		assign hs_nxt[i] = cmd_act_r[i] & cmd_side_r[i] & ~off;
		assign ls_nxt[i] = cmd_act_r[i] & ~cmd_side_r[i] & ~off;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			oc_ch_r <= hbd_pkg::BRIDGE_RST;
			ol_ch_r <= hbd_pkg::BRIDGE_RST;
			high_side_switch <= hbd_pkg::BRIDGE_RST;
			low_side_switch <= hbd_pkg::BRIDGE_RST;
		end else begin
			oc_ch_r <= oc_ch_nxt;
			ol_ch_r <= ol_ch_nxt;
			high_side_switch <= hs_nxt;
			low_side_switch <= ls_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	oc_sets_off_a: assert property (
		oc_s[0] |=> oc_ch_r[0] && !high_side_switch[0] &&
			!low_side_switch[0])
		else $error("overcurrent did not latch or switch off");

	oc_flag_hold_a: assert property (
		stat_word[hbd_pkg::BIT_OC] && !clr_evt |=>
			stat_word[hbd_pkg::BIT_OC])
		else $error("overcurrent flag dropped without clear");

	supply_all_off_a: assert property (
		psf_s |=> (high_side_switch | low_side_switch) == 6'h00)
		else $error("supply failure left a bridge on");

	supply_flag_free_a: assert property (
		$fell(psf_s) |-> !stat_word[hbd_pkg::BIT_PSF])
		else $error("supply flag stuck after recovery");

	ol_latch_set_a: assert property (
		ol_s != 6'h00 |=> stat_word[hbd_pkg::BIT_OL])
		else $error("open load did not set flag");

	ol_gated_off_a: assert property (
		ol_ch_r[1] && ol_en_r && !clr_evt |=>
			!high_side_switch[1] && !low_side_switch[1])
		else $error("open load with shutdown left bridge on");

	ol_no_off_a: assert property (
		ol_ch_r[2] && !ol_en_r && !global_off && !oc_ch_nxt[2] &&
			cmd_act_r[2] |=> high_side_switch[2] | low_side_switch[2])
		else $error("open load without shutdown turned bridge off");

	ol_flag_hold_a: assert property (
		ol_ch_r[3] && !clr_evt |=> ol_ch_r[3] [*1])
		else $error("open load latch dropped without clear");

	tsd_all_off_a: assert property (
		tsd_s |=> (high_side_switch | low_side_switch) == 6'h00)
		else $error("thermal shutdown left a bridge on");

	first_word_mask_a: assert property (
		first_r && csn_s |=> (snap_r & ~hbd_pkg::FIRST_MASK) == 16'h0000)
		else $error("first word carries latched bits");

	clear_on_end_a: assert property (
		clr_evt && oc_s == 6'h00 |=> !stat_word[hbd_pkg::BIT_OC])
		else $error("status clear missed overcurrent flag");

	snap_frozen_a: assert property (
		!csn_s |=> $stable(snap_r))
		else $error("status word changed during a frame");
endmodule

// ### hbd_host_model.sv
// Host serial master model that sends control words and reads status
`timescale 1ns/10ps
module hbd_host_model (
	// Link pins
	output logic link_sclk,
	output logic spi_csn_n,
	output logic spi_sdi,
	input wire logic spi_sdo
);
	initial begin
		link_sclk = 1'b0;
		spi_csn_n = 1'b1;
		spi_sdi = 1'b0;
	end

	// ----------------------------------------------------------------
	// Frame
	// ----------------------------------------------------------------
	// Clock stands still outside frames; 6 ns period inside
	task automatic frame(input logic [15:0] ctl, output logic [15:0] sts);
		spi_csn_n = 1'b0;
		#50;
		for (int i = 15; i >= 0; i--) begin
			spi_sdi = ctl[i];
			#3 link_sclk = 1'b1;
			#3 link_sclk = 1'b0;
			sts[i] = spi_sdo;
		end
		#3 spi_csn_n = 1'b1;
		// Idle data line must not look like a held bit
		spi_sdi = ~spi_sdi;
		#70;
	endtask
endmodule

// ### halfbridge_diag_status_word_tb_top.sv
// Self-checking bench for the diagnosis status word block
`timescale 1ns/10ps
module halfbridge_diag_status_word_tb_top;
	logic clock;
	logic sys_rst;
	logic link_sclk, spi_csn_n, spi_sdi, spi_sdo, spi_sdo_oe;
	logic [5:0] oc_det, ol_det, high_side_switch, low_side_switch;
	logic sup_f, tw, shutdown_temp_threshold;
	logic [15:0] sts;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	logic oe_seen = 1'b0;

	// Output enable as seen by the link while a frame shifts
	always @(posedge link_sclk) begin
		oe_seen <= spi_sdo_oe;
	end

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	hbd_diag_word dut_u (.clock(clock), .sys_rst(sys_rst),
		.link_sclk(link_sclk), .spi_csn_n(spi_csn_n), .spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
		.overcurrent_det(oc_det), .openload_det(ol_det),
		.supply_fault(sup_f), .temp_warn(tw), .temp_shutdown(shutdown_temp_threshold),
		.high_side_switch(high_side_switch),
		.low_side_switch(low_side_switch));

	hbd_host_model host_u (.link_sclk(link_sclk), .spi_csn_n(spi_csn_n),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hang guard, well above the roughly 500 cycles needed
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clock);
	endtask

	// Lets input changes settle before and control effects after
	task automatic xfer(input logic [15:0] ctl);
		wait_clk(4);
		check({15'h0000, spi_sdo_oe}, 16'h0000);
		host_u.frame(ctl, sts);
		check({15'h0000, oe_seen}, 16'h0001);
		wait_clk(6);
		check({15'h0000, spi_sdo_oe}, 16'h0000);
	endtask

	task automatic chk_out(input logic [5:0] hs, input logic [5:0] ls);
		check({10'h000, high_side_switch}, {10'h000, hs});
		check({10'h000, low_side_switch}, {10'h000, ls});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_first();
		tw = 1'b1;
		ol_det = 6'h04;
		xfer(16'h1fd4);
		check(sts, 16'h0001);
		ol_det = 6'h00;
		chk_out(6'h2a, 6'h15);
		$display("test first_word done");
	endtask

	task automatic t_latch();
		tw = 1'b0;
		xfer(16'h1fd4);
		check(sts, 16'h3fd4);
		xfer(16'hbfd4);
		check(sts, 16'h3fd4);
		xfer(16'h3fd4);
		check(sts, 16'h1fd4);
		$display("test openload_latch done");
	endtask

	task automatic t_olsd();
		ol_det = 6'h01;
		wait_clk(6);
		chk_out(6'h2a, 6'h14);
		ol_det = 6'h00;
		xfer(16'h3fd4);
		check(sts, 16'h3f54);
		xfer(16'hbfd4);
		chk_out(6'h2a, 6'h15);
		$display("test openload_shutdown done");
	endtask

	task automatic t_oc();
		oc_det = 6'h20;
		wait_clk(6);
		chk_out(6'h0a, 6'h15);
		oc_det = 6'h00;
		xfer(16'h1fd4);
		check(sts, 16'h8f94);
		xfer(16'hdfd4);
		xfer(16'h9fd4);
		check(sts, 16'h8f94);
		xfer(16'h1fd4);
		check(sts, 16'h1fd4);
		chk_out(6'h2a, 6'h15);
		$display("test overcurrent done");
	endtask

	task automatic t_supply_temp();
		sup_f = 1'b1;
		wait_clk(6);
		chk_out(6'h00, 6'h00);
		xfer(16'h1fd4);
		check(sts & 16'h4000, 16'h4000);
		sup_f = 1'b0;
		xfer(16'h1fd4);
		check(sts & 16'hc001, 16'h0000);
		tw = 1'b1;
		shutdown_temp_threshold = 1'b1;
		wait_clk(6);
		chk_out(6'h00, 6'h00);
		xfer(16'h1fd4);
		check(sts & 16'h0001, 16'h0001);
		tw = 1'b0;
		shutdown_temp_threshold = 1'b0;
		xfer(16'h1fd4);
		check(sts & 16'h0001, 16'h0000);
		$display("test supply_thermal done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		oc_det = 6'h00;
		ol_det = 6'h00;
		sup_f = 1'b0;
		tw = 1'b0;
		shutdown_temp_threshold = 1'b0;
		wait_clk(10);
		sys_rst = 1'b0;
		wait_clk(4);
		t_first();
		t_latch();
		t_olsd();
		t_oc();
		t_supply_temp();
		finish_test();
	end
endmodule
